// file: rtl/adc_port_pkg.sv
// constants and types shared by the dual converter output and configuration port
// assumes a 200 MHz reference clock on the configuration side
`default_nettype none

package adc_port_pkg;
  // clock and detection timing
  localparam int REF_CLK_PERIOD_PS = 5000;
  localparam int ENC_MAX_PERIOD_NS = 1000;
  localparam int SE_WINDOW_CYC = (2 * ENC_MAX_PERIOD_NS * 1000 + REF_CLK_PERIOD_PS - 1)
                                 / REF_CLK_PERIOD_PS;
  localparam int PIPE_LATENCY = 6;

  // serial frame: one read/write bit, seven address bits, eight data bits
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
  localparam logic [6:0] ADDR_POWER = 7'h01;
  localparam logic [6:0] ADDR_TIMING = 7'h02;
  localparam logic [6:0] ADDR_OUTPUT = 7'h03;
  localparam logic [6:0] ADDR_FORMAT = 7'h04;
  localparam logic [7:0] CFG_REG_RESET = 8'h00;

  // field positions inside the mode control registers
  localparam int SOFT_RESET_BIT = 7;
  localparam int PWR_LSB = 0;
  localparam int DCS_BIT = 0;
  localparam int PHASE_LSB = 1;
  localparam int MODE_LSB = 0;
  localparam int TWOS_BIT = 0;

  // output modes
  localparam logic [1:0] MODE_FULL_CMOS = 2'h0;
  localparam logic [1:0] MODE_DDR_CMOS = 2'h1;
  localparam logic [1:0] MODE_DDR_LVDS = 2'h2;

  // configuration word carried into the encode domain
  localparam int X_MODE_LSB = 0;
  localparam int X_PHASE_LSB = 2;
  localparam int X_TWOS_BIT = 4;
  localparam int CFG_X_W = 5;
  localparam logic [CFG_X_W-1:0] CFG_X_RESET = 5'h00;

  // synchronised pin vector
  localparam int PIN_COUNT = 6;
  localparam int PIN_CS = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_SDO = 3;
  localparam int PIN_STRAP = 4;
  localparam int PIN_ENCN = 5;
  localparam logic [PIN_COUNT-1:0] PIN_RESET_VALUE = 6'h01;

  typedef enum logic [1:0] {PORT_HEAD, PORT_DATA, PORT_DONE} port_state_t;
endpackage

`default_nettype wire

// file: rtl/cfg_port_if.sv
// serial pins and decoded mode fields between the top and the serial port engine
// assumes every signal here lives on the reference clock
`default_nettype none

interface cfg_port_if;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo_pull_low;
  logic dcs_en;
  logic [1:0] clk_phase;
  logic [1:0] out_mode;
  logic twos;
  logic [1:0] pwr;

  modport port (input cs_n, sck, sdi,
                output sdo_pull_low, dcs_en, clk_phase, out_mode, twos, pwr);
  modport top (output cs_n, sck, sdi,
               input sdo_pull_low, dcs_en, clk_phase, out_mode, twos, pwr);
endinterface

`default_nettype wire

// file: rtl/dual_adc_output_and_config_port.sv
// top of the dual converter digital side: pin sync, mode select, output path
// assumes a running encode clock during reset and core codes stable at its rising edge
// Contract
// R1: strap low makes the four pins a serial mode register interface.
// R2: strap high makes the four pins static mode select inputs.
// R3: serial data shifts only while chip select is low.
// R4: each serial input bit is sampled on the serial clock rising edge.
// R5: readback drives register contents on the serial output; host latches on falling.
// R6: serial output is open drain, pulls low only; writes need no readback.
// R7: parallel mode: chip select level enables the duty cycle stabilizer.
// R8: parallel mode: serial clock level selects the digital output mode.
// R9: parallel mode: serial in and out levels select power-down state.
// R10: each encode rising edge starts a conversion of both channels.
// R11: complementary encode held at ground means single-ended encode mode.
// R12: full-rate data changes at the output clock falling edge unless phase delayed.
// R13: negative output clock is the exact inverse of the positive one.
// R14: output clock phase is delayable through the mode control registers.
// R15: full-rate: each channel on its own 16-line bus, bit 15 most significant.
// R16: full-rate: one range flag per channel follows its current output sample.
// R17: two's complement: zeros just above mid-scale, ones just below it.
// R18: ddr: even bit while output clock low, odd bit while high.
// R19: ddr: shared flag carries channel 2 while clock low, channel 1 while high.
// R20: serial output released whenever chip select is high.
// R21: both channel buses and flags update together on the same edge.
`default_nettype none

module dual_adc_output_and_config_port
  import adc_port_pkg::*;
#(
  parameter int SAMPLE_W = 16,
  parameter int LATENCY = PIPE_LATENCY,
  parameter int SE_WINDOW = SE_WINDOW_CYC
)
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic programming_mode_strap,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_in,
  output logic sdo_out,
  output logic sdo_oe,
  input wire logic encode_clock_pos,
  input wire logic encode_clock_neg,
  input wire logic [SAMPLE_W-1:0] ch1_core_code,
  input wire logic ch1_core_range,
  input wire logic [SAMPLE_W-1:0] ch2_core_code,
  input wire logic ch2_core_range,
  output logic [SAMPLE_W-1:0] ch1_sample_bus,
  output logic [SAMPLE_W-1:0] ch2_sample_bus,
  output logic ch1_range_flag,
  output logic ch2_range_flag,
  output logic shared_range_flag,
  output logic data_output_clock_pos,
  output logic data_output_clock_neg,
  output logic duty_cycle_stabilizer_en,
  output logic [1:0] power_down_mode,
  output logic [1:0] output_mode,
  output logic encode_single_ended
);
  localparam int SE_CNT_W = $clog2(SE_WINDOW + 1);
  localparam logic [SE_CNT_W-1:0] SE_LAST = SE_CNT_W'(SE_WINDOW);
  localparam int SLOT_W = 2 * SAMPLE_W + 2;
  localparam int HALF_W = SAMPLE_W / 2;
  localparam logic [SAMPLE_W-1:0] MSB_MASK = {1'b1, {(SAMPLE_W-1){1'b0}}};

  // reference clock domain state
  typedef struct packed {
    logic [PIN_COUNT-1:0] s1;
    logic [PIN_COUNT-1:0] s2;
    logic [PIN_COUNT-1:0] s3;
    logic [PIN_COUNT-1:0] filt;
    logic [SE_CNT_W-1:0] se_cnt;
    logic single_ended;
    logic dcs;
    logic [1:0] pwr;
    logic [1:0] mode;
    logic [1:0] phase;
    logic twos;
  } ref_regs_t;

  // encode clock domain state
  typedef struct packed {
    logic rs1;
    logic rs2;
    logic [CFG_X_W-1:0] c1;
    logic [CFG_X_W-1:0] c2;
    logic [CFG_X_W-1:0] c3;
    logic [CFG_X_W-1:0] cfg;
    logic [LATENCY-1:0][SLOT_W-1:0] pipe;
  } enc_regs_t;

  localparam ref_regs_t REF_RESET = '{s1: PIN_RESET_VALUE, s2: PIN_RESET_VALUE,
    s3: PIN_RESET_VALUE, filt: PIN_RESET_VALUE, mode: MODE_FULL_CMOS, default: '0};

  ref_regs_t r_q;
  ref_regs_t r_d;
  enc_regs_t e_q;
  enc_regs_t e_d;

  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] pin_diff;
  logic parallel;
  logic [1:0] pin_pwr;
  logic [SLOT_W-1:0] slot_in;
  logic [SLOT_W-1:0] w;
  logic [SAMPLE_W-1:0] w1;
  logic [SAMPLE_W-1:0] w2;
  logic f1;
  logic f2;
  logic [1:0] e_mode;
  logic [1:0] e_phase;
  logic e_twos;
  logic e_ddr;
  logic [HALF_W-1:0] ddr1;
  logic [HALF_W-1:0] ddr2;

  cfg_port_if cfg ();

  function automatic logic is_ddr(input logic [1:0] m);
    is_ddr = (m == MODE_DDR_CMOS) || (m == MODE_DDR_LVDS);
  endfunction

  function automatic logic [SAMPLE_W-1:0] fmt_code(input logic [SAMPLE_W-1:0] c,
                                                  input logic twos);
    // offset binary from the core; flipping the msb gives two's complement
    fmt_code = twos ? (c ^ MSB_MASK) : c;
  endfunction

  assign pins = {encode_clock_neg, programming_mode_strap, sdo_in, sdi, sck, cs_n};
  assign pin_diff = r_q.s2 ^ r_q.s3;
  assign parallel = r_q.filt[PIN_STRAP];
  assign pin_pwr = {r_q.filt[PIN_SDI], r_q.filt[PIN_SDO]};

  // strap high holds the serial engine idle  see R1 see R2
  assign cfg.cs_n = parallel | r_q.filt[PIN_CS];
  assign cfg.sck = r_q.filt[PIN_SCK];
  assign cfg.sdi = r_q.filt[PIN_SDI];

  serial_cfg_port u_port (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .bus(cfg)
  );

  // open drain: only the enable moves; sdo is an input in parallel mode  see R6 see R9
  assign sdo_out = 1'b0;
  assign sdo_oe = cfg.sdo_pull_low & ~parallel;

  always_comb
  begin
    r_d = r_q;
    // three stages; a change counts once the second and third agree
    r_d.s1 = pins;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    r_d.filt = (~pin_diff & r_q.s3) | (pin_diff & r_q.filt);
    // any high on the complement input restarts the window  see R11
    if (r_q.filt[PIN_ENCN])
      r_d.se_cnt = '0;
    else if (r_q.se_cnt != SE_LAST)
      r_d.se_cnt = r_q.se_cnt + SE_CNT_W'(1);
    r_d.single_ended = (r_d.se_cnt == SE_LAST);
    if (parallel) // see R2
    begin
      r_d.dcs = r_q.filt[PIN_CS]; // see R7
      r_d.mode = r_q.filt[PIN_SCK] ? MODE_DDR_CMOS : MODE_FULL_CMOS; // see R8
      r_d.pwr = pin_pwr; // see R9
      r_d.phase = 2'h0;
      r_d.twos = 1'b0;
    end
    else // see R1
    begin
      r_d.dcs = cfg.dcs_en;
      r_d.mode = cfg.out_mode;
      r_d.pwr = cfg.pwr;
      r_d.phase = cfg.clk_phase; // see R14
      r_d.twos = cfg.twos;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      r_q <= REF_RESET;
    else
      r_q <= r_d;
  end

  assign duty_cycle_stabilizer_en = r_q.dcs;
  assign power_down_mode = r_q.pwr;
  assign output_mode = r_q.mode;
  assign encode_single_ended = r_q.single_ended;

  // encode domain
  assign slot_in = {ch2_core_range, fmt_code(ch2_core_code, e_twos),
                    ch1_core_range, fmt_code(ch1_core_code, e_twos)}; // see R17

  always_comb
  begin
    e_d = e_q;
    e_d.rs1 = resetn;
    e_d.rs2 = e_q.rs1;
    // quasi-static word: taken only once two synced samples agree
    e_d.c1 = {r_q.twos, r_q.phase, r_q.mode};
    e_d.c2 = e_q.c1;
    e_d.c3 = e_q.c2;
    if (!e_q.rs2)
    begin
      e_d.cfg = CFG_X_RESET;
      e_d.pipe = '0;
    end
    else
    begin
      if (e_q.c2 == e_q.c3)
        e_d.cfg = e_q.c3;
      // both channels enter together on the same edge  see R10 see R21
      e_d.pipe = {e_q.pipe[LATENCY-2:0], slot_in};
    end
  end

  always_ff @(posedge encode_clock_pos)
  begin
    e_q <= e_d;
  end

  assign e_mode = e_q.cfg[X_MODE_LSB +: 2];
  assign e_phase = e_q.cfg[X_PHASE_LSB +: 2];
  assign e_twos = e_q.cfg[X_TWOS_BIT];
  assign e_ddr = is_ddr(e_mode);
  assign w = e_q.pipe[LATENCY-1];
  assign w1 = w[SAMPLE_W-1:0];
  assign f1 = w[SAMPLE_W];
  assign w2 = w[2*SAMPLE_W:SAMPLE_W+1];
  assign f2 = w[SLOT_W-1];

  // data moves on the encode rise, i.e. the output clock's fall; phase
  // field bit 1 delays by half a cycle, bit 0 has no finer clock to use
  assign data_output_clock_pos = ~encode_clock_pos ^ e_phase[1]; // see R12 see R14
  assign data_output_clock_neg = ~data_output_clock_pos; // see R13

  generate
    for (genvar i = 0; i < HALF_W; i++)
    begin : g_ddr
      assign ddr1[i] = data_output_clock_pos ? w1[2*i+1] : w1[2*i]; // see R18
      assign ddr2[i] = data_output_clock_pos ? w2[2*i+1] : w2[2*i]; // see R18
    end
  endgenerate

  // upper lines idle low in ddr modes  see R15 see R18
  assign ch1_sample_bus = e_ddr ? {{HALF_W{1'b0}}, ddr1} : w1;
  assign ch2_sample_bus = e_ddr ? {{HALF_W{1'b0}}, ddr2} : w2;
  assign ch1_range_flag = ~e_ddr & f1; // see R16
  assign ch2_range_flag = ~e_ddr & f2; // see R16
  assign shared_range_flag = e_ddr & (data_output_clock_pos ? f1 : f2); // see R19

  a_sdo_idle_release: assert property ( // see R20
    @(posedge ref_clk) disable iff (!resetn)
    cfg.cs_n |=> !sdo_oe)
  else $error("sdo pulled low after chip select high");

  a_sdo_pull_only: assert property ( // see R6
    @(posedge ref_clk) disable iff (!resetn)
    sdo_oe |-> !sdo_out)
  else $error("sdo driven high");

  a_par_dcs_follow: assert property ( // see R7
    @(posedge ref_clk) disable iff (!resetn)
    parallel |=> duty_cycle_stabilizer_en == $past(r_q.filt[PIN_CS]))
  else $error("stabilizer enable not following chip select");

  a_par_mode_pin: assert property ( // see R8
    @(posedge ref_clk) disable iff (!resetn)
    parallel && r_q.filt[PIN_SCK] |=> output_mode == MODE_DDR_CMOS)
  else $error("output mode not following serial clock pin");

  a_par_power_pins: assert property ( // see R9
    @(posedge ref_clk) disable iff (!resetn)
    parallel |=> power_down_mode == $past(pin_pwr))
  else $error("power-down not following pins");

  a_ser_cs_blocks: assert property ( // see R3
    @(posedge ref_clk) disable iff (!resetn)
    !parallel && cfg.cs_n |=> $stable(cfg.out_mode) && $stable(cfg.pwr) && $stable(cfg.twos))
  else $error("register changed with chip select high");

  a_ser_mode_reg: assert property ( // see R1
    @(posedge ref_clk) disable iff (!resetn)
    !parallel |=> output_mode == $past(cfg.out_mode))
  else $error("serial mode register not applied");

  a_se_detect_clear: assert property ( // see R11
    @(posedge ref_clk) disable iff (!resetn)
    r_q.filt[PIN_ENCN] |=> !encode_single_ended)
  else $error("single-ended flagged while complement toggles");

  a_data_output_clock_pos_inverse: assert property ( // see R13
    @(posedge ref_clk) disable iff (!resetn)
    data_output_clock_neg == !data_output_clock_pos)
  else $error("output clocks not complementary");

  a_data_latency: assert property ( // see R15
    @(posedge encode_clock_pos) disable iff (!e_q.rs2)
    $past(e_q.rs2, LATENCY) && !e_ddr && !e_twos && e_q.cfg == $past(e_q.cfg, LATENCY)
    |-> ch1_sample_bus == $past(ch1_core_code, LATENCY)
        && ch2_sample_bus == $past(ch2_core_code, LATENCY))
  else $error("full-rate sample latency wrong");

  a_twos_code: assert property ( // see R17
    @(posedge encode_clock_pos) disable iff (!e_q.rs2)
    $past(e_q.rs2, LATENCY) && !e_ddr && e_twos && e_q.cfg == $past(e_q.cfg, LATENCY)
    |-> ch1_sample_bus == ($past(ch1_core_code, LATENCY) ^ MSB_MASK))
  else $error("two's complement coding wrong");

  a_range_full: assert property ( // see R16
    @(posedge encode_clock_pos) disable iff (!e_q.rs2)
    $past(e_q.rs2, LATENCY) && !e_ddr && e_q.cfg == $past(e_q.cfg, LATENCY)
    |-> ch1_range_flag == $past(ch1_core_range, LATENCY)
        && ch2_range_flag == $past(ch2_core_range, LATENCY))
  else $error("range flag not with its sample");

  a_ddr_odd_high: assert property ( // see R18
    @(posedge encode_clock_pos) disable iff (!e_q.rs2)
    e_ddr && !e_phase[1] |-> ch1_sample_bus[0] == w1[1] && shared_range_flag == f1)
  else $error("odd bit or channel 1 flag missing with clock high");

  a_ddr_even_low: assert property ( // see R19
    @(negedge encode_clock_pos) disable iff (!e_q.rs2)
    e_ddr && !e_phase[1] |-> ch2_sample_bus[0] == w2[0] && shared_range_flag == f2)
  else $error("even bit or channel 2 flag missing with clock low");

  c_serial_write: cover property (
    @(posedge ref_clk) disable iff (!resetn)
    !parallel ##1 $changed(cfg.out_mode));

  c_readback: cover property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(sdo_oe));

  c_ddr_mode: cover property (
    @(posedge encode_clock_pos) disable iff (!e_q.rs2)
    e_ddr && shared_range_flag);

  c_single_ended: cover property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(encode_single_ended));
endmodule

`default_nettype wire

// file: rtl/serial_cfg_port.sv
// serial engine for the mode control registers, with open-drain readback
// assumes cs_n, sck and sdi are already synchronised and filtered on ref_clk
`default_nettype none

module serial_cfg_port
  import adc_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  cfg_port_if.port bus
);
  typedef struct packed {
    port_state_t st;
    logic [2:0] cnt;
    logic [6:0] sh;
    logic rd;
    logic [6:0] addr;
    logic [7:0] rdsh;
    logic sck_prev;
    logic sdo_low;
    logic [7:0] r_pwr;
    logic [7:0] r_tim;
    logic [7:0] r_out;
    logic [7:0] r_fmt;
  } port_regs_t;

  localparam port_regs_t PORT_RESET = '{st: PORT_HEAD, r_pwr: CFG_REG_RESET,
    r_tim: CFG_REG_RESET, r_out: CFG_REG_RESET, r_fmt: CFG_REG_RESET, default: '0};

  port_regs_t state_q;
  port_regs_t state_d;
  logic sck_rise;
  logic [7:0] word;

  function automatic logic [7:0] read_reg(input port_regs_t s, input logic [6:0] a);
    case (a)
      ADDR_POWER: read_reg = s.r_pwr;
      ADDR_TIMING: read_reg = s.r_tim;
      ADDR_OUTPUT: read_reg = s.r_out;
      ADDR_FORMAT: read_reg = s.r_fmt;
      default: read_reg = 8'h00;
    endcase
  endfunction

  always_comb
  begin
    state_d = state_q;
    sck_rise = bus.sck & ~state_q.sck_prev;
    word = {state_q.sh, bus.sdi};
    state_d.sck_prev = bus.sck;
    if (bus.cs_n)
    begin
      // frame aborted, partial writes dropped, line released  see R3 see R20
      state_d.st = PORT_HEAD;
      state_d.cnt = 3'h0;
      state_d.sdo_low = 1'b0;
    end
    else if (sck_rise) // see R4
    begin
      state_d.sh = word[6:0];
      state_d.cnt = state_q.cnt + 3'h1;
      case (state_q.st)
        PORT_HEAD:
        begin
          if (state_q.cnt == LAST_BIT)
          begin
            state_d.st = PORT_DATA;
            state_d.rd = word[7];
            state_d.addr = word[6:0];
            state_d.rdsh = read_reg(state_q, word[6:0]);
            state_d.sdo_low = word[7] & ~state_d.rdsh[7]; // see R5
          end
        end
        PORT_DATA:
        begin
          // pull low only for a zero bit, else leave it to the pull-up  see R6
          state_d.rdsh = {state_q.rdsh[6:0], 1'b0};
          state_d.sdo_low = state_q.rd & ~state_q.rdsh[6]; // see R5
          if (state_q.cnt == LAST_BIT)
          begin
            state_d.st = PORT_DONE;
            state_d.sdo_low = 1'b0;
            if (!state_q.rd)
            begin
              case (state_q.addr)
                ADDR_SOFT_RESET:
                begin
                  if (word[SOFT_RESET_BIT])
                  begin
                    state_d.r_pwr = CFG_REG_RESET;
                    state_d.r_tim = CFG_REG_RESET;
                    state_d.r_out = CFG_REG_RESET;
                    state_d.r_fmt = CFG_REG_RESET;
                  end
                end
                ADDR_POWER: state_d.r_pwr = word;
                ADDR_TIMING: state_d.r_tim = word;
                ADDR_OUTPUT: state_d.r_out = word;
                ADDR_FORMAT: state_d.r_fmt = word;
                default: state_d.r_fmt = state_q.r_fmt;
              endcase
            end
          end
        end
        PORT_DONE: state_d.cnt = state_q.cnt;
        default: state_d.st = PORT_DONE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      state_q <= PORT_RESET;
    else
      state_q <= state_d;
  end

  assign bus.sdo_pull_low = state_q.sdo_low;
  assign bus.dcs_en = state_q.r_tim[DCS_BIT];
  assign bus.clk_phase = state_q.r_tim[PHASE_LSB +: 2];
  assign bus.out_mode = state_q.r_out[MODE_LSB +: 2];
  assign bus.twos = state_q.r_fmt[TWOS_BIT];
  assign bus.pwr = state_q.r_pwr[PWR_LSB +: 2];
endmodule

`default_nettype wire

// file: tb/dual_adc_output_and_config_port_tb.sv
// self-checking bench for the dual converter output and configuration port
// assumes host_model owns the encode clock and serial pins
`default_nettype none

module dual_adc_output_and_config_port_tb
  import adc_port_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic strap = 1'b0;
  logic se = 1'b0;
  logic sdo_par = 1'b0;
  logic [15:0] c1 = 16'h0001;
  logic [15:0] c2 = 16'hf00f;
  logic r1 = 1'b0;
  logic r2 = 1'b0;
  logic sdo_out, sdo_oe, sdo_wire, sdo_lvl, enc_p, enc_n, cs_n, sck, sdi;
  logic [15:0] b1, b2;
  logic f1, f2, fs, ckp, ckn, dcs, se_det;
  logic [1:0] pwr, om;
  logic chk = 1'b0;
  logic ramp = 1'b1;
  logic tw = 1'b0;
  logic [33:0] q[$];
  logic [7:0] rd;
  int num_errors = 0;
  int n_tests = 0;

  initial
    forever #2.5 ref_clk = ~ref_clk;
  assign sdo_wire = sdo_oe ? 1'b0 : 1'b1;
  // in parallel mode the host drives the sdo pin itself
  assign sdo_lvl = strap ? sdo_par : sdo_wire;

  dual_adc_output_and_config_port #(.SE_WINDOW(16)) dual_adc_output_and_config_port_inst (
    .ref_clk(ref_clk), .resetn(resetn), .programming_mode_strap(strap),
    .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_in(sdo_lvl), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .encode_clock_pos(enc_p), .encode_clock_neg(enc_n),
    .ch1_core_code(c1), .ch1_core_range(r1), .ch2_core_code(c2), .ch2_core_range(r2),
    .ch1_sample_bus(b1), .ch2_sample_bus(b2), .ch1_range_flag(f1), .ch2_range_flag(f2),
    .shared_range_flag(fs), .data_output_clock_pos(ckp), .data_output_clock_neg(ckn),
    .duty_cycle_stabilizer_en(dcs), .power_down_mode(pwr), .output_mode(om),
    .encode_single_ended(se_det));

  host_model host_model_inst (
    .ref_clk(ref_clk), .se(se), .sdo_wire(sdo_wire), .enc_p(enc_p), .enc_n(enc_n),
    .cs_n(cs_n), .sck(sck), .sdi(sdi));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [15:0] pick(input logic [15:0] v, input int o);
    pick = 16'h0000;
    for (int i = 0; i < 8; i++)
      pick[i] = v[2*i+o];
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_model_inst.frame({1'b0, a, d}, rd);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] e, input string n);
    host_model_inst.frame({1'b1, a, 8'h00}, rd);
    check(n, {8'h00, rd}, {8'h00, e});
  endtask

  task automatic clk_look(input logic hi);
    @(posedge enc_p);
    #4;
    check("data_output_clock_pos pos", 16'(ckp), 16'(hi));
    check("data_output_clock_pos neg", 16'(ckn), 16'(!hi));
  endtask

  task automatic ddr_look(input logic [15:0] a, input logic [15:0] b);
    @(posedge enc_p);
    #4;
    check("ddr ch1 even", b1, pick(a, 0));
    check("ddr ch2 even", b2, pick(b, 0));
    check("ddr flag low", 16'(fs), 16'(r2));
    @(negedge enc_p);
    #4;
    check("ddr ch1 odd", b1, pick(a, 1));
    check("ddr flag high", 16'(fs), 16'(r1));
    check("full flag off", 16'(f1), 16'h0000);
  endtask

  // pipeline model: word standing after a rise is the capture five rises earlier
  always @(posedge enc_p)
  begin
    q.push_back({r1, c1, r2, c2});
    if (q.size() > 7)
      void'(q.pop_front());
    if (ramp)
    begin
      c1 <= c1 + 16'h1357;
      c2 <= c2 - 16'h0101;
      r1 <= c1[3];
      r2 <= c2[5];
    end
  end

  // looked at mid-cycle, away from the edge that launches the word
  always @(negedge enc_p)
  begin
    if (chk && q.size() == 7)
    begin
      check("ch1 word", b1, q[1][32:17] ^ {tw, 15'h0000});
      check("ch2 word", b2, q[1][15:0] ^ {tw, 15'h0000});
      check("ch1 flag", 16'(f1), 16'(q[1][33]));
      check("ch2 flag", 16'(f2), 16'(q[1][16]));
    end
  end

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    num_errors++;
    give_verdict();
  end

  initial
  begin
    // longer than eight cycles: the encode domain needs three rises too
    repeat (24) @(posedge ref_clk);
    resetn <= 1'b1;
    tick(2);
    check("oe idle", 16'(sdo_oe), 16'h0000);
    check("mode reset", 16'(om), 16'h0000);
    repeat (20) @(posedge enc_p);
    chk <= 1'b1;
    clk_look(1'b0);
    repeat (20) @(posedge enc_p);
    chk <= 1'b0;
    wr(ADDR_FORMAT, 8'h01);
    rdc(ADDR_FORMAT, 8'h01, "format read");
    rdc(7'h7f, 8'h00, "unmapped read");
    tick(1);
    check("oe released", 16'(sdo_oe), 16'h0000);
    check("sdo level", 16'(sdo_out), 16'h0000);
    @(posedge enc_p);
    ramp <= 1'b0;
    tw <= 1'b1;
    @(negedge enc_p);
    c1 <= 16'h8000;
    c2 <= 16'h7fff;
    repeat (8) @(posedge enc_p);
    chk <= 1'b1;
    repeat (10) @(posedge enc_p);
    chk <= 1'b0;
    wr(ADDR_OUTPUT, 8'h01);
    tick(1);
    check("mode ddr", 16'(om), 16'h0001);
    @(negedge enc_p);
    c1 <= 16'ha5c3;
    c2 <= 16'h3c5a;
    r1 <= 1'b1;
    r2 <= 1'b0;
    repeat (10) @(posedge enc_p);
    ddr_look(16'h25c3, 16'hbc5a);
    wr(ADDR_OUTPUT, 8'h02);
    tick(1);
    check("mode lvds", 16'(om), 16'h0002);
    repeat (10) @(posedge enc_p);
    ddr_look(16'h25c3, 16'hbc5a);
    wr(ADDR_TIMING, 8'h05);
    tick(1);
    check("stabilizer on", 16'(dcs), 16'h0001);
    repeat (10) @(posedge enc_p);
    clk_look(1'b1);
    wr(ADDR_POWER, 8'h03);
    tick(1);
    check("power serial", 16'(pwr), 16'h0003);
    wr(ADDR_SOFT_RESET, 8'h80);
    tick(1);
    check("soft mode", 16'(om), 16'h0000);
    check("soft power", 16'(pwr), 16'h0000);
    @(posedge ref_clk);
    se <= 1'b1;
    tick(40);
    check("single ended", 16'(se_det), 16'h0001);
    @(posedge ref_clk);
    se <= 1'b0;
    tick(10);
    check("differential", 16'(se_det), 16'h0000);
    @(posedge ref_clk);
    strap <= 1'b1;
    sdo_par <= 1'b0;
    host_model_inst.pins(1'b1, 1'b1, 1'b1);
    tick(20);
    check("par stabilizer", 16'(dcs), 16'h0001);
    check("par mode", 16'(om), 16'h0001);
    check("par power", 16'(pwr), 16'h0002);
    check("par oe", 16'(sdo_oe), 16'h0000);
    @(posedge ref_clk);
    sdo_par <= 1'b1;
    host_model_inst.pins(1'b0, 1'b0, 1'b0);
    tick(20);
    check("par stab off", 16'(dcs), 16'h0000);
    check("par mode full", 16'(om), 16'h0000);
    check("par power b0", 16'(pwr), 16'h0001);
    give_verdict();
  end
endmodule

`default_nettype wire

// file: tb/host_model.sv
// host side model: encode clock source and serial configuration master
// assumes callers run on ref_clk and an sdo wire with a pull-up
`default_nettype none

module host_model
  import adc_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic se,
  input wire logic sdo_wire,
  output logic enc_p,
  output logic enc_n,
  output logic cs_n,
  output logic sck,
  output logic sdi
);
  timeunit 1ns;
  timeprecision 1ps;
  // sck high time, 130 ns of a 270 ns sck period, slow enough for readback
  localparam int HALF = 26;

  initial
  begin
    enc_p = 1'b0;
    #3.3;
    forever #16 enc_p = ~enc_p;
  end
  assign enc_n = se ? 1'b0 : ~enc_p;

  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end

  task automatic frame(input logic [15:0] w, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge ref_clk);
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge ref_clk);
      sdi <= w[i];
      repeat (HALF) @(posedge ref_clk);
      sck <= 1'b1;
      repeat (HALF) @(posedge ref_clk);
      sck <= 1'b0;
      @(posedge ref_clk);
      if (i >= 1 && i <= 8)
        rd[i-1] = sdo_wire;
    end
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic pins(input logic c, input logic s, input logic d);
    @(posedge ref_clk);
    cs_n <= c;
    sck <= s;
    sdi <= d;
  endtask
endmodule

`default_nettype wire
